// [verilog/flash_seq_host.v]
// Host-side sequencer for page erase and row rewrite of program flash.
// Assumes a device register port with write strobe, read strobe and data.
// Summary of operation
// [R01] One row per program, erase whole page
// [R02] Page contents read before erasing by user
// [R03] Erase uses code 0010, erase and enable
// [R04] Page pointer and base set before erase
// [R05] Keys 0x55 then 0xAA before start
// [R06] Device refuses operations without unlock keys
// [R07] Start bit begins cycle, CPU stalls
// [R08] Device clears start bit when done
// [R09] Row program code 0001, erase bit cleared
// [R10] Load 64 words into buffers per row
// [R11] Repeat rows, advancing page pointer, 512 total
// [R12] Two idle slots after start write
// [R13] Wait full programming time before complete
// [R14] Key and start writes kept uninterruptible
// [R15] Only 0x55 then 0xAA arms unlock
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module flash_seq_host #(
  parameter ROW_WORDS = `ROW_WORDS,
  parameter PAGE_ROWS = `PAGE_ROWS
)(
  input wire i_clk_sys,
  input wire i_rstn,
  input wire i_erase_req,
  input wire i_row_req,
  input wire [15:0] i_page_addr,
  input wire [15:0] i_wdata,
  input wire i_wvalid,
  input wire i_dev_busy,
  input wire [15:0] i_dev_rdata,
  output reg o_wready,
  output reg o_busy,
  output reg o_done,
  output reg o_dev_wr,
  output reg o_dev_rd,
  output reg [1:0] o_dev_sel,
  output reg [15:0] o_dev_wdata,
  output reg o_hold_irq
);
// ============================================================
// Reset release and pin synchronisers
reg rst_a_q, rst_b_q;
always @(posedge i_clk_sys or negedge i_rstn)
begin
  if (!i_rstn)
  begin
    rst_a_q <= 1'b0;
    rst_b_q <= 1'b0;
  end
  else
  begin
    rst_a_q <= 1'b1;
    rst_b_q <= rst_a_q;
  end
end
wire rstn = rst_b_q;
reg busy_m_q, busy_s_q, start_m_q, start_s_q;
always @(posedge i_clk_sys or negedge rstn)
begin
  if (!rstn)
  begin
    busy_m_q <= 1'b0;
    busy_s_q <= 1'b0;
    start_m_q <= 1'b0;
    start_s_q <= 1'b0;
  end
  else
  begin
    busy_m_q <= i_dev_busy;
    busy_s_q <= busy_m_q;
    start_m_q <= i_dev_rdata[`CTL_START_BIT];
    start_s_q <= start_m_q;
  end
end
// ============================================================
// Sequencer
localparam S_IDLE = 4'h0;
localparam S_CTL = 4'h1;
localparam S_PAGE = 4'h2;
localparam S_BASE = 4'h3;
localparam S_KEY1 = 4'h4;
localparam S_KEY2 = 4'h5;
localparam S_GO = 4'h6;
localparam S_SETTLE = 4'h7;
localparam S_POLL = 4'h8;
localparam S_LOAD = 4'h9;
localparam S_NEXT = 4'ha;
reg [3:0] st_q;
reg erase_q;
reg [15:0] page_q;
reg [6:0] word_q;
reg [3:0] row_q;
reg [1:0] settle_q;
reg [1:0] poll_q;
always @(posedge i_clk_sys or negedge rstn)
begin
  if (!rstn)
  begin
    st_q <= S_IDLE;
    erase_q <= 1'b0;
    page_q <= 16'h0000;
    word_q <= 7'h00;
    row_q <= 4'h0;
    settle_q <= 2'h0;
    poll_q <= 2'h0;
    o_wready <= 1'b0;
    o_busy <= 1'b0;
    o_done <= 1'b0;
    o_dev_wr <= 1'b0;
    o_dev_rd <= 1'b0;
    o_dev_sel <= 2'h0;
    o_dev_wdata <= 16'h0000;
    o_hold_irq <= 1'b0;
  end
  else
  begin
    o_dev_wr <= 1'b0;
    o_dev_rd <= 1'b0;
    o_done <= 1'b0;
    case (st_q)
      S_IDLE:
      begin
        o_busy <= 1'b0;
        if (i_erase_req || i_row_req)
        begin
          erase_q <= i_erase_req;
          page_q <= i_page_addr;
          row_q <= 4'h0;
          o_busy <= 1'b1;
          st_q <= S_CTL;
        end
      end
      S_CTL:
      begin
        o_dev_wr <= 1'b1;
        o_dev_sel <= `REG_SEL_CONTROL;
        if (erase_q)
          o_dev_wdata <= `CTL_VAL_ERASE; // [R03] [R01]
        else
          o_dev_wdata <= `CTL_VAL_ROW; // [R09]
        st_q <= erase_q ? S_PAGE : S_LOAD;
        word_q <= 7'h00;
      end
      S_PAGE:
      begin
        o_dev_wr <= 1'b1;
        o_dev_sel <= `REG_SEL_PAGE; // [R04] [R11]
        o_dev_wdata <= page_q;
        st_q <= erase_q ? S_BASE : S_KEY1;
      end
      S_BASE:
      begin
        o_dev_wr <= 1'b1;
        o_dev_sel <= `REG_SEL_WBUF; // [R04]
        o_dev_wdata <= 16'h0000;
        st_q <= S_KEY1;
      end
      S_LOAD:
      begin
        o_wready <= 1'b1;
        if (i_wvalid && o_wready)
        begin
          o_dev_wr <= 1'b1;
          o_dev_sel <= `REG_SEL_WBUF; // [R10]
          o_dev_wdata <= i_wdata;
          word_q <= word_q + 7'h01;
          if (word_q == ROW_WORDS - 1)
          begin
            o_wready <= 1'b0;
            st_q <= S_PAGE;
          end
        end
      end
      S_KEY1:
      begin
        o_hold_irq <= 1'b1; // [R14]
        o_dev_wr <= 1'b1;
        o_dev_sel <= `REG_SEL_KEY;
        o_dev_wdata <= `KEY_FIRST; // [R05] [R06] [R15]
        st_q <= S_KEY2;
      end
      S_KEY2:
      begin
        o_dev_wr <= 1'b1;
        o_dev_sel <= `REG_SEL_KEY;
        o_dev_wdata <= `KEY_SECOND; // [R05] [R15]
        st_q <= S_GO;
      end
      S_GO:
      begin
        o_dev_wr <= 1'b1;
        o_dev_sel <= `REG_SEL_CONTROL;
        o_dev_wdata <= (erase_q ? `CTL_VAL_ERASE : `CTL_VAL_ROW)
          | `CTL_VAL_START; // [R07]
        settle_q <= 2'h0;
        st_q <= S_SETTLE;
      end
      S_SETTLE:
      begin
        settle_q <= settle_q + 2'h1; // [R12]
        if (settle_q == `SETTLE_CYCLES - 1)
        begin
          o_hold_irq <= 1'b0;
          poll_q <= 2'h0;
          st_q <= S_POLL;
        end
      end
      S_POLL:
      begin
        o_dev_rd <= 1'b1;
        o_dev_sel <= `REG_SEL_CONTROL;
        // Let the synchronisers see busy first
        if (poll_q != `POLL_WAIT)
          poll_q <= poll_q + 2'h1;
        else if (!busy_s_q && !start_s_q) // [R08] [R13]
          st_q <= S_NEXT;
      end
      S_NEXT:
      begin
        if (erase_q || row_q == PAGE_ROWS - 1)
        begin
          o_done <= 1'b1;
          o_busy <= 1'b0;
          st_q <= S_IDLE;
        end
        else
        begin
          row_q <= row_q + 4'h1;
          page_q <= page_q + 16'h0001; // [R11]
          st_q <= S_CTL;
        end
      end
      default:
        st_q <= S_IDLE;
    endcase
  end
end
endmodule

// [shared/flash_seq_defines.vh]
// Constants for the flash erase/program sequencer host.
// Assumes a 16-bit register port into the device's flash controller.
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH
// ============================================================
// Register selects on the device port
`define REG_SEL_CONTROL 2'h0
`define REG_SEL_KEY 2'h1
`define REG_SEL_PAGE 2'h2
`define REG_SEL_WBUF 2'h3
// ============================================================
// Control register fields
`define CTL_START_BIT 15
`define CTL_PROGRAM_ENABLE_BIT_BIT 14
`define CTL_ERASE_BIT 6
`define CTL_OP_LSB 0
`define OP_CODE_ERASE 4'h2
`define OP_CODE_ROW 4'h1
`define CTL_VAL_ERASE 16'h4042
`define CTL_VAL_ROW 16'h4001
`define CTL_VAL_START 16'h8000
// ============================================================
// Unlock keys, geometry and timing
`define KEY_FIRST 16'h0055
`define KEY_SECOND 16'h00aa
`define ROW_WORDS 64
`define PAGE_ROWS 8
`define SETTLE_CYCLES 2
`define POLL_WAIT 2
`endif

// [tb/dev_model.sv]
// Device model: control, key, page and buffer registers.
// Assumes one-cycle write strobes from the host on the system clock.
`timescale 1ns/1ps
module dev_model #(parameter OP_CYC = 8'd20)(
  input wire i_clk_sys,
  input wire i_rstn,
  input wire i_wr,
  input wire [1:0] i_sel,
  input wire [15:0] i_wdata,
  output wire o_busy,
  output wire [15:0] o_rdata
);
  reg [1:0] key_q;
  reg [7:0] cnt_q;
  reg [15:0] ctl_q, pg_q, n_ops, n_buf;
  assign o_busy = cnt_q != 8'h0;
  assign o_rdata = ctl_q;
  always @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
    begin
      {key_q, cnt_q, ctl_q, pg_q, n_ops, n_buf} <= 74'h0;
    end
    else
    begin
      if (cnt_q == 8'h1)
        ctl_q[15] <= 1'b0;
      if (o_busy)
        cnt_q <= cnt_q - 8'h1;
      else if (i_wr && i_sel == 2'h1)
        key_q <= (i_wdata == 16'h0055) ? 2'h1 :
          (key_q == 2'h1 && i_wdata == 16'h00aa) ? 2'h2 : 2'h0;
      else if (i_wr && i_sel == 2'h0)
      begin
        ctl_q <= {1'b0, i_wdata[14:0]};
        if (i_wdata[15])
          key_q <= 2'h0;
        if (i_wdata[15] && key_q == 2'h2 && ctl_q[14])
        begin
          ctl_q[15] <= 1'b1;
          cnt_q <= OP_CYC;
          n_ops <= n_ops + 16'h1;
        end
      end
      else if (i_wr && i_sel == 2'h2)
        pg_q <= i_wdata;
      else if (i_wr)
        n_buf <= n_buf + 16'h1;
    end
endmodule

// [tb/flash_seq_host_asserts.sv]
// Checker on the sequencer host ports.
// Assumes bind to flash_seq_host, one clock domain.
`timescale 1ns/1ps
module flash_seq_host_asserts(
  input wire i_clk_sys, i_rstn, i_erase_req, i_row_req, i_wvalid,
  input wire i_dev_busy, o_wready, o_busy, o_done, o_dev_wr, o_dev_rd,
  input wire [15:0] i_page_addr, i_wdata, i_dev_rdata, o_dev_wdata,
  input wire [1:0] o_dev_sel,
  input wire o_hold_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  wire kw = o_dev_wr && o_dev_sel == 2'h1;
  wire cw = o_dev_wr && o_dev_sel == 2'h0;
  wire sw = cw && o_dev_wdata[15];
  a_req_taken: assert property (!o_busy && (i_erase_req || i_row_req)
    |=> o_busy) else $error("request not taken");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_key_second: assert property (kw && o_dev_wdata == 16'h0055
    |=> kw && o_dev_wdata == 16'h00aa) else $error("second key missing");
  a_start_follows: assert property (kw && o_dev_wdata == 16'h00aa
    |=> sw) else $error("start not after keys");
  a_start_code: assert property (sw |-> o_hold_irq &&
    (o_dev_wdata == 16'hc042 || o_dev_wdata == 16'hc001))
    else $error("bad start value");
  a_setup_code: assert property (cw && !o_dev_wdata[15] |->
    o_dev_wdata == 16'h4042 || o_dev_wdata == 16'h4001)
    else $error("bad setup value");
  a_key_held: assert property (kw |-> o_hold_irq)
    else $error("key write not held");
  a_settle_quiet: assert property (sw |=> (!o_dev_wr && !o_dev_rd)[*2])
    else $error("access during settle");
  a_idle_quiet: assert property (!o_busy |-> !o_dev_wr)
    else $error("write while idle");
  a_load_write: assert property (o_wready && i_wvalid |=>
    o_dev_wr && o_dev_sel == 2'h3 && o_dev_wdata == $past(i_wdata))
    else $error("buffer word not written");
  a_done_settled: assert property (o_done |->
    !i_dev_busy && !i_dev_rdata[15]) else $error("done while device busy");
  cover property (o_wready && i_wvalid);
  cover property (cw && o_dev_wdata == 16'h4042);
  cover property (cw && o_dev_wdata == 16'h4001);
  cover property (o_done);
endmodule
bind flash_seq_host flash_seq_host_asserts i_chk(.*);

// [tb/tb_flash_seq_host.sv]
// Testbench for the sequencer host with a device model.
// Assumes 4 words a row and 2 rows a page.
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module tb_flash_seq_host;
  reg i_clk_sys = 0, i_rstn = 0, er_q = 0, rw_q = 0;
  wire wr, rd, busy, done, dbusy, wrdy, hirq;
  wire [1:0] sel;
  wire [15:0] wd, rdat;
  reg wv_q = 0;
  reg [15:0] wdat_q = 16'h1234;
  integer bad_count = 0, n_tests = 0, cyc = 0, i;
  reg [29:0] rows [0:2];
  reg [15:0] ops0, buf0;
  initial forever #5 i_clk_sys = ~i_clk_sys;
  flash_seq_host #(.ROW_WORDS(4), .PAGE_ROWS(2)) i_flash_seq_host(
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_erase_req(er_q),
    .i_row_req(rw_q), .i_page_addr(16'h0012), .i_wdata(wdat_q),
    .i_wvalid(wv_q), .i_dev_busy(dbusy), .i_dev_rdata(rdat),
    .o_wready(wrdy), .o_busy(busy), .o_done(done), .o_dev_wr(wr),
    .o_dev_rd(rd), .o_dev_sel(sel), .o_dev_wdata(wd), .o_hold_irq(hirq));
  always @(posedge i_clk_sys)
  begin
    wv_q <= ~wv_q;
    wdat_q <= wdat_q + 16'h0001;
  end
  dev_model i_dev_model(.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_wr(wr), .i_sel(sel), .i_wdata(wd), .o_busy(dbusy), .o_rdata(rdat));
  task chk(input [15:0] got, input [15:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task tally_and_finish;
  begin
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task go(input e, input r);
  begin
    ops0 = i_dev_model.n_ops;
    buf0 = i_dev_model.n_buf;
    @(posedge i_clk_sys) {er_q, rw_q} <= {e, r};
    @(posedge i_clk_sys) {er_q, rw_q} <= 2'b00;
    while (done !== 1'b1) @(negedge i_clk_sys);
  end
  endtask
  always @(posedge i_clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    rows[0] = {2'b10, 4'd1, 8'd1, 16'h0012};
    rows[1] = {2'b01, 4'd2, 8'd8, 16'h0013};
    rows[2] = {2'b11, 4'd1, 8'd1, 16'h0012};
    repeat (3) @(posedge i_clk_sys);
    chk({busy, wr, rd, done, wrdy, hirq}, 16'h0);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    for (i = 0; i < 3; i = i + 1)
    begin
      go(rows[i][29], rows[i][28]);
      chk(i_dev_model.n_ops - ops0, rows[i][27:24]);
      chk(i_dev_model.n_buf - buf0, rows[i][23:16]);
      chk(i_dev_model.pg_q, rows[i][15:0]);
      chk({wrdy, hirq}, 16'h0);
      chk(i_dev_model.ctl_q, rows[i][29] ? `CTL_VAL_ERASE : `CTL_VAL_ROW);
    end
    ops0 = i_dev_model.n_ops;
    @(posedge i_clk_sys) er_q <= 1'b1;
    @(posedge i_clk_sys) {er_q, rw_q} <= 2'b01;
    repeat (3) @(posedge i_clk_sys);
    rw_q <= 1'b0;
    while (done !== 1'b1) @(negedge i_clk_sys);
    chk(i_dev_model.n_ops - ops0, 16'h1);
    @(posedge i_clk_sys) rw_q <= 1'b1;
    repeat (12) @(posedge i_clk_sys);
    i_rstn <= 1'b0;
    rw_q <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    chk({busy, wr, rd, done, wrdy, hirq}, 16'h0);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    go(1'b1, 1'b0);
    chk(i_dev_model.n_ops - ops0, 16'h1);
    chk(i_dev_model.ctl_q, `CTL_VAL_ERASE);
    tally_and_finish;
  end
endmodule
